// [orf_pkg.sv]
// Purpose: constants for the power calibration record formatter
// Assumes: one drive clock, byte-wide sector stream
// Notes: What this block does
package orf_pkg;
  localparam int REC_BYTES = 2048;
  localparam int SLOT_BYTES = 128;
  localparam int NUM_SLOTS = 4;
  localparam logic [6:0] OFS_WS1 = 7'h40;
  localparam logic [6:0] OFS_WS1_END = 7'h43;
  localparam logic [6:0] OFS_PWR = 7'h44;
  localparam logic [6:0] OFS_PCA = 7'h50;
  localparam logic [6:0] OFS_PCA_END = 7'h53;
  localparam logic [6:0] OFS_RUN_END = 7'h6B;
  localparam logic [6:0] OFS_WS5 = 7'h6C;
  localparam logic [6:0] OFS_WS5_END = 7'h71;
  localparam logic [6:0] OFS_RDS_HI = 7'h72;
  localparam logic [6:0] OFS_RDS_LO = 7'h73;
  localparam logic [7:0] DISC_INCREMENTAL = 8'h02;
  // AHB register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_SLOT_SEL = 8'h08;
  localparam logic [7:0] A_WS1 = 8'h0C;
  localparam logic [7:0] A_WS5_LO = 8'h10;
  localparam logic [7:0] A_WS5_HI = 8'h14;
  localparam logic [7:0] A_PCA = 8'h18;
  localparam logic [7:0] A_RDS = 8'h1C;
  localparam logic [7:0] A_P_WS1 = 8'h20;
  localparam logic [7:0] A_P_WS5_LO = 8'h24;
  localparam logic [7:0] A_P_WS5_HI = 8'h28;
  localparam logic [7:0] A_P_PCA = 8'h2C;
  localparam logic [7:0] A_P_RDS = 8'h30;
  localparam logic [7:0] A_DISC = 8'h34;
  localparam logic [7:0] A_P_SLOTS = 8'h38;
  localparam int CTRL_BUILD = 0;
  localparam int CTRL_PARSE = 1;
  typedef enum logic [1:0] {ORF_IDLE = 2'b00, ORF_BUILD = 2'b01, ORF_PARSE = 2'b11} orf_state_e;
endpackage

// [orf_skid.sv]
`timescale 1ns/1ps
// Purpose: two-entry valid/ready buffer
// Assumes: single clock
// Notes: full throughput, no word lost on stall
module orf_skid #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic         rd_reg;
  logic         wr_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  // handshake terms
  assign push      = in_valid && (cnt_reg != 2'd2);
  assign pop       = out_ready && (cnt_reg != 2'd0);
  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = mem_reg[rd_reg];

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push) begin
        wr_reg <= ~wr_reg;
      end
      if (pop) begin
        rd_reg <= ~rd_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// [orf_record.sv]
`timescale 1ns/1ps
// Purpose: build and parse the 2048-byte power calibration record
// Assumes: AHB-Lite single word transfers, byte stream with valid/ready
// Notes: build streams the record out; parse captures fields of a chosen slot
module orf_record
  import orf_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // outgoing sector byte stream
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  // incoming sector byte stream
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  // status
  output logic             busy
);
  orf_state_e     state_reg;
  logic [ADDR_W-1:0] pos_reg;
  logic [1:0]     slot_sel_reg;
  logic [3:0]     slot_used_reg;
  logic [31:0]    ws1_reg;
  logic [47:0]    ws5_reg;
  logic [31:0]    pca_reg;
  logic [15:0]    rds_reg;
  logic [7:0]     disc_reg;
  logic [31:0]    p_ws1_reg;
  logic [47:0]    p_ws5_reg;
  logic [31:0]    p_pca_reg;
  logic [15:0]    p_rds_reg;
  logic [3:0]     p_slots_reg;
  logic           done_reg;
  logic           ap_wr_reg;
  logic [7:0]     ap_addr_reg;
  logic [31:0]    rd_next;
  logic [7:0]     byte_next;
  logic [6:0]     rel;
  logic [1:0]     slot;
  logic           in_slots;
  logic [2:0]     boff;
  logic           b_valid;
  logic           b_ready;
  logic           b_fire;
  logic           rx_fire;
  logic           rds_ok;

  // position in record split into slot and relative byte
  assign rel      = pos_reg[6:0];
  assign slot     = pos_reg[8:7];
  assign in_slots = (pos_reg < ADDR_W'(SLOT_BYTES * NUM_SLOTS));
  assign b_valid  = (state_reg == ORF_BUILD);
  assign b_fire   = b_valid && b_ready;
  assign rx_fire  = (state_reg == ORF_PARSE) && rx_valid;
  assign rx_ready = (state_reg == ORF_PARSE);
  // state word is meaningful only in incremental mode
  assign rds_ok   = (disc_reg == DISC_INCREMENTAL);

  // byte generator for build; unused regions yield zero
  always_comb begin
    byte_next = 8'h00;
    boff      = 3'd0;
    if (in_slots && slot_used_reg[slot]) begin
      if (rel >= OFS_WS1 && rel <= OFS_WS1_END) begin
        boff      = 3'(rel - OFS_WS1);
        byte_next = ws1_reg[8*(3-boff[1:0]) +: 8];
      end else if (rel >= OFS_PCA && rel <= OFS_PCA_END) begin
        boff      = 3'(rel - OFS_PCA);
        byte_next = pca_reg[8*(3-boff[1:0]) +: 8];
      end else if (rel >= OFS_WS5 && rel <= OFS_WS5_END) begin
        boff      = 3'(rel - OFS_WS5);
        byte_next = ws5_reg[8*(5-boff) +: 8];
      end else if (rel == OFS_RDS_HI && rds_ok) begin
        byte_next = rds_reg[15:8];
      end else if (rel == OFS_RDS_LO && rds_ok) begin
        byte_next = {rds_reg[7:1], 1'b0};
      end
      // id, serial, model, power, time stamp, running info stay zero
    end
  end

  // output buffer on the sector stream
  orf_skid #(.W(9)) u_txbuf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (b_valid),
    .in_ready  (b_ready),
    .in_data   ({(pos_reg == ADDR_W'(REC_BYTES - 1)), byte_next}),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_last, tx_data})
  );

  // sequencer: one 2048-byte pass per build or parse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ORF_IDLE;
      pos_reg   <= '0;
      done_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ORF_IDLE: begin
          pos_reg <= '0;
          if (ap_wr_reg && ap_addr_reg == A_CTRL) begin
            if (hwdata[CTRL_BUILD]) begin
              state_reg <= ORF_BUILD;
              done_reg  <= 1'b0;
            end else if (hwdata[CTRL_PARSE]) begin
              state_reg <= ORF_PARSE;
              done_reg  <= 1'b0;
            end
          end
        end
        ORF_BUILD: begin
          if (b_fire) begin
            pos_reg <= pos_reg + 1'b1;
            if (pos_reg == ADDR_W'(REC_BYTES - 1)) begin
              state_reg <= ORF_IDLE;
              done_reg  <= 1'b1;
            end
          end
        end
        ORF_PARSE: begin
          if (rx_fire) begin
            pos_reg <= pos_reg + 1'b1;
            if (pos_reg == ADDR_W'(REC_BYTES - 1)) begin
              state_reg <= ORF_IDLE;
              done_reg  <= 1'b1;
            end
          end
        end
        default: state_reg <= ORF_IDLE;
      endcase
    end
  end

  // parse capture of the selected slot's fields
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      p_ws1_reg   <= '0;
      p_ws5_reg   <= '0;
      p_pca_reg   <= '0;
      p_rds_reg   <= '0;
      p_slots_reg <= '0;
    end else if (rx_fire) begin
      if (pos_reg == '0) begin
        p_slots_reg <= '0;
      end
      // a slot counts as present when the first byte of its WS1 field is nonzero
      if (in_slots && rel == OFS_WS1 && rx_data != 8'h00) begin
        p_slots_reg[slot] <= 1'b1;
      end
      if (in_slots && slot == slot_sel_reg) begin
        if (rel >= OFS_WS1 && rel <= OFS_WS1_END) begin
          p_ws1_reg <= {p_ws1_reg[23:0], rx_data};
        end
        if (rel >= OFS_PCA && rel <= OFS_PCA_END) begin
          p_pca_reg <= {p_pca_reg[23:0], rx_data};
        end
        if (rel >= OFS_WS5 && rel <= OFS_WS5_END) begin
          p_ws5_reg <= {p_ws5_reg[39:0], rx_data};
        end
        if (rel == OFS_RDS_HI) begin
          p_rds_reg[15:8] <= rx_data;
        end
        if (rel == OFS_RDS_LO) begin
          p_rds_reg[7:0] <= {rx_data[7:1], 1'b0};
        end
      end
    end
  end

  // ahb address phase capture for writes; reads are answered at the address edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ap_wr_reg   <= 1'b0;
      ap_addr_reg <= '0;
    end else if (hready) begin
      ap_wr_reg   <= hsel && htrans[1] && hwrite;
      ap_addr_reg <= haddr[7:0];
    end
  end

  // writable configuration
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slot_sel_reg  <= '0;
      slot_used_reg <= 4'h1;
      ws1_reg       <= '0;
      ws5_reg       <= '0;
      pca_reg       <= '0;
      rds_reg       <= '0;
      disc_reg      <= '0;
    end else if (ap_wr_reg) begin
      case (ap_addr_reg)
        A_SLOT_SEL: begin
          slot_sel_reg  <= hwdata[1:0];
          slot_used_reg <= hwdata[11:8];
        end
        A_WS1:    ws1_reg        <= hwdata;
        A_WS5_LO: ws5_reg[31:0]  <= hwdata;
        A_WS5_HI: ws5_reg[47:32] <= hwdata[15:0];
        A_PCA:    pca_reg        <= hwdata;
        A_RDS:    rds_reg        <= {hwdata[15:1], 1'b0};
        A_DISC:   disc_reg       <= hwdata[7:0];
        default:  disc_reg       <= disc_reg;
      endcase
    end
  end

  // read mux on the address phase, so the word stands through the data phase
  // a read right behind a write to the same register still sees the old value
  always_comb begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      A_STATUS:   rd_next = {29'h0, done_reg, state_reg};
      A_SLOT_SEL: rd_next = {20'h0, slot_used_reg, 6'h0, slot_sel_reg};
      A_WS1:      rd_next = ws1_reg;
      A_WS5_LO:   rd_next = ws5_reg[31:0];
      A_WS5_HI:   rd_next = {16'h0, ws5_reg[47:32]};
      A_PCA:      rd_next = pca_reg;
      A_RDS:      rd_next = {16'h0, rds_reg};
      A_P_WS1:    rd_next = p_ws1_reg;
      A_P_WS5_LO: rd_next = p_ws5_reg[31:0];
      A_P_WS5_HI: rd_next = {16'h0, p_ws5_reg[47:32]};
      A_P_PCA:    rd_next = p_pca_reg;
      // zero state word is invalid: flag bit 16
      A_P_RDS:    rd_next = {15'h0, (p_rds_reg != 16'h0), p_rds_reg};
      A_DISC:     rd_next = {24'h0, disc_reg};
      A_P_SLOTS:  rd_next = {27'h0, (p_pca_reg != 32'h0), p_slots_reg};
      default:    rd_next = 32'h0000_0000;
    endcase
  end

  // registered bus outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      busy      <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      busy      <= (state_reg != ORF_IDLE);
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end
endmodule

// [orf_far.sv]
`timescale 1ns/1ps
// Purpose: far side of the sector stream, sink and replay source
// Assumes: one clock, valid/ready on both streams
// Notes: random stalls; idle rx data flips to its inverse on every idle cycle
module orf_far (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // record from the block
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // record back into the block
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       play
);
  logic [7:0]  mem [0:2047];
  logic [10:0] widx, ridx;
  logic        sending;
  int          seed = 32'h309E226C;
  // stall at random, keep every accepted byte of the 2048-byte record
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      widx <= 11'h000;
    end else begin
      tx_ready <= ($random(seed) & 3) != 0;
      if (tx_valid && tx_ready) begin
        mem[widx] <= tx_data;
        widx <= widx + 11'h001;
      end
    end
  end
  // replay the stored record with random gaps, holding each byte until taken
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      ridx <= 11'h000;
      sending <= 1'b0;
    end else if (play) begin
      sending <= 1'b1;
      ridx <= 11'h000;
    end else if (rx_valid && !rx_ready) begin
      rx_valid <= 1'b1;
    end else if (sending && ($random(seed) & 3) != 0) begin
      rx_valid <= 1'b1;
      rx_data <= mem[ridx];
      ridx <= ridx + 11'h001;
      sending <= ridx != 11'h7FF;
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule

// [orf_record_chk.sv]
`timescale 1ns/1ps
// Purpose: port checks on the outgoing record stream
// Assumes: every build sends exactly one 2048-byte record
// Notes: byte position counted on accepted bytes
module orf_record_chk
  import orf_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // outgoing stream
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last
);
  logic [ADDR_W-1:0] pos_reg;
  logic [6:0]        ofs;
  logic              take;
  assign take = tx_valid && tx_ready;
  assign ofs = pos_reg[6:0];
  // position within the record
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) pos_reg <= '0;
    else if (take) pos_reg <= pos_reg + 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_held;
    tx_valid && $stable(tx_data) && $stable(tx_last);
  endsequence
  a_tx_hold: assert property (s_stall |=> s_held) else $error("stalled byte changed");
  a_last_pos: assert property (take |-> tx_last == (&pos_reg)) else $error("last flag misplaced");
  a_last_valid: assert property (tx_last |-> tx_valid) else $error("last without valid");
  a_tail_zero: assert property (take && pos_reg[ADDR_W-1:9] != 0 |-> tx_data == 8'h00)
    else $error("tail byte not zero");
  a_slot_pad: assert property (take && ofs >= 7'h74 |-> tx_data == 8'h00) else $error("slot pad not zero");
  a_ids_zero: assert property (take && ofs < OFS_WS1 |-> tx_data == 8'h00) else $error("id byte not zero");
  a_pwr_zero: assert property (take && ofs inside {[OFS_PWR:7'h4F], [7'h54:OFS_RUN_END]} |-> tx_data == 8'h00)
    else $error("power byte not zero");
  a_sum_bit0: assert property (take && ofs == OFS_RDS_LO |-> !tx_data[0]) else $error("sum bit 0 set");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
endmodule
bind orf_record orf_record_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .nrst(nrst), .hreadyout(hreadyout),
  .hresp(hresp), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

// [orf_record_tb.sv]
`timescale 1ns/1ps
// Purpose: build two records, parse them back, check bytes and fields
// Assumes: zero-wait bus, read data stands in the data phase
// Notes: slot 0 alone with incremental mode, then all four slots
module orf_record_tb;
  import orf_pkg::*;
  logic        sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, play = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, ws1, ws5l, ws5h, power_calibration_area, rds, r;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, tx_valid, tx_ready, tx_last, rx_valid, rx_ready, busy;
  logic [7:0]  tx_data, rx_data, disc;
  logic [3:0]  mask;
  logic [8:0]  q [$];
  int          seed = 32'h309E226C, miscompares = 0, n_compared = 0;
  always #25 sys_clk = ~sys_clk;
  orf_record DUT (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy));
  orf_far far (.sys_clk(sys_clk), .nrst(nrst), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .play(play));
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for bus ready, or for the block idle with all bytes seen
  task wait_on(input int lim, input bit idle);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > lim) check("wait bound", 1, 0);
      if (k > lim) report_and_stop();
    end while (idle ? (busy !== 1'b0 || q.size() != 0) : hreadyout !== 1'b1);
  endtask
  // one single-word transfer; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_on(50, 0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(50, 0);
    r = hrdata;
  endtask
  // expected record byte
  function logic [7:0] exp_b(int i);
    int o;
    logic [63:0] f;
    o = i % 128;
    f = {ws5h[15:0], ws5l, rds[15:1], 1'b0};
    if (i >= 512 || !mask[i / 128]) return 8'h00;
    if (o >= 64 && o <= 67) return ws1[8 * (67 - o) +: 8];
    if (o >= 80 && o <= 83) return power_calibration_area[8 * (83 - o) +: 8];
    if (o >= 108 && o <= 113) return f[8 * (115 - o) +: 8];
    if (o >= 114 && o <= 115 && disc == DISC_INCREMENTAL) return f[8 * (115 - o) +: 8];
    return 8'h00;
  endfunction
  // every accepted byte is matched against the oldest note
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (q.size() == 0) check("extra byte", 1, 0);
      else check("record byte", {tx_last, tx_data}, q.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    ahb(0, 8'h3C, 0);
    check("unmapped", r, 0);
    for (int c = 0; c < 2; c++) begin
      ws1 = $random(seed) | 32'h0100_0000;
      ws5l = $random(seed);
      ws5h = $random(seed) & 32'h0000FFFF;
      power_calibration_area = $random(seed);
      rds = $random(seed) & 32'h0000FFFF | 32'h1;
      disc = c ? 8'h01 : DISC_INCREMENTAL;
      mask = c ? 4'hF : 4'h1;
      ahb(1, A_WS1, ws1);
      ahb(1, A_WS5_LO, ws5l);
      ahb(1, A_WS5_HI, ws5h);
      ahb(1, A_PCA, power_calibration_area);
      ahb(1, A_RDS, rds);
      ahb(1, A_DISC, {24'h0, disc});
      ahb(1, A_SLOT_SEL, {20'h0, mask, 6'h0, c ? 2'h3 : 2'h0});
      for (int i = 0; i < 2048; i++) q.push_back({i == 2047, exp_b(i)});
      ahb(1, A_CTRL, 32'h1);
      repeat (2) @(posedge sys_clk);
      check("busy", busy, 1);
      wait_on(20000, 1);
      ahb(0, A_STATUS, 0);
      check("status", r, 32'h0000_0004);
      ahb(1, A_CTRL, 32'h2);
      play <= 1'b1;
      @(posedge sys_clk);
      play <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wait_on(20000, 1);
      ahb(0, A_P_WS1, 0);
      check("parsed ws1", r, ws1);
      ahb(0, A_P_WS5_LO, 0);
      check("parsed ws5", r, ws5l);
      ahb(0, A_P_WS5_HI, 0);
      check("parsed ws5 hi", r, ws5h);
      ahb(0, A_P_PCA, 0);
      check("parsed pca", r, power_calibration_area);
      ahb(0, A_P_RDS, 0);
      check("parsed sum", r, c ? 0 : {15'h0, 1'b1, rds[15:1], 1'b0});
      ahb(0, A_P_SLOTS, 0);
      check("slots", r, {27'h0, power_calibration_area != 0, mask});
    end
    report_and_stop();
  end
endmodule
